// File: bbsd_addr_former.sv
// Operand address former for the bit-oriented instructions.
// Assumes the index base and bank pointer are stable during decode.
`timescale 1ns/1ps
module bbsd_addr_former (
  // Operand fields in, file address out
  bbsd_addr_if.former p
);

  // ----------------------------------------------------------------
  // Mode and address selection
  // ----------------------------------------------------------------
  always_comb begin
    if (p.acc_flag) begin
      p.mode = bbsd_pkg::AM_BANKED;
      p.addr = {p.bank_sel, p.file_lit};
    end else if (p.ext_en && (p.file_lit <= bbsd_pkg::ACCESS_LOW_LIMIT)) begin
      p.mode = bbsd_pkg::AM_INDEXED;
      // Wraps within the data space; no carry out
      p.addr = p.index_base + {4'h0, p.file_lit};
    end else begin
      p.mode = bbsd_pkg::AM_ACCESS;
      // Low part maps to bank 0, high part to the special bank
      if (p.file_lit <= bbsd_pkg::ACCESS_LOW_LIMIT) begin
        p.addr = {bbsd_pkg::ACCESS_LOW_BANK, p.file_lit};
      end else begin
        p.addr = {bbsd_pkg::ACCESS_HIGH_BANK, p.file_lit};
      end
    end
  end

endmodule // bbsd_addr_former

// File: bbsd_addr_if.sv
// Carrier between the decoder and its operand address former.
// Assumes both ends sit in the same clock domain; purely combinational.
`timescale 1ns/1ps
interface bbsd_addr_if;
  logic [7:0] file_lit;
  logic acc_flag;
  logic [3:0] bank_sel;
  logic ext_en;
  logic [bbsd_pkg::ADDR_W-1:0] index_base;
  logic [bbsd_pkg::ADDR_W-1:0] addr;
  bbsd_pkg::bbsd_amode_t mode;

  modport former (
    input file_lit,
    input acc_flag,
    input bank_sel,
    input ext_en,
    input index_base,
    output addr,
    output mode
  );

  modport user (
    output file_lit,
    output acc_flag,
    output bank_sel,
    output ext_en,
    output index_base,
    input addr,
    input mode
  );
endinterface

// File: bbsd_core.sv
// Decode and execute of relative jump, bit force-one and two bit-test skips.
// Assumes the fetched word at pc is valid at Q4 and the file memory reads combinationally.
//
// What this block does
// - Relative jump: prefix 1101, then 0, then 11-bit signed offset.
// - Jump target is incremented PC plus twice the signed offset.
// - Relative jump always takes two cycles; second cycle is a no-operation.
// - Prefix 1000 sets chosen bit of addressed register; flags untouched.
// - Access flag zero selects the access bank.
// - Access flag one takes upper address bits from bank pointer.
// - Extended set, flag zero, address at most 5Fh: indexed literal offset.
// - Prefix 1011 skips next instruction when the tested bit is zero.
// - Prefix 1010 skips next instruction when the tested bit is one.
// - Taken skip discards fetched instruction, runs a no-operation; two cycles.
// - Skipping a two-word instruction takes three cycles in total.
`timescale 1ns/1ps
module bbsd_core (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Program fetch
  input wire logic [15:0] fetch_word,
  input wire logic fetch_two_word,
  output logic fetch_strobe,
  output logic [20:0] pc,
  // File register access
  output logic [11:0] file_addr,
  output logic file_rd,
  input wire logic [7:0] file_rdata,
  output logic file_wr,
  output logic [7:0] file_wdata,
  // Addressing controls
  input wire logic [3:0] bank_select_pointer,
  input wire logic ext_set_en,
  input wire logic [11:0] index_base,
  // Status
  output logic status_we,
  output logic flush_active,
  output logic op_unhandled
);

  // ----------------------------------------------------------------
  // Instruction cycle phases
  // ----------------------------------------------------------------
  bbsd_pkg::bbsd_phase_t phase_q;
  logic q4;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      phase_q <= bbsd_pkg::PH_Q1;
    end else begin
      case (phase_q)
        bbsd_pkg::PH_Q1: phase_q <= bbsd_pkg::PH_Q2;
        bbsd_pkg::PH_Q2: phase_q <= bbsd_pkg::PH_Q3;
        bbsd_pkg::PH_Q3: phase_q <= bbsd_pkg::PH_Q4;
        bbsd_pkg::PH_Q4: phase_q <= bbsd_pkg::PH_Q1;
        default: phase_q <= bbsd_pkg::PH_Q1;
      endcase
    end
  end

  assign q4 = (phase_q == bbsd_pkg::PH_Q4);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [15:0] ir_q;
  logic [1:0] flush_cnt_q;
  logic flushing;
  bbsd_pkg::bbsd_op_t dec_op;
  bbsd_pkg::bbsd_op_t exec_op;
  logic [20:0] jump_ofs;

  always_comb begin
    case (ir_q[bbsd_pkg::OPC_MSB:bbsd_pkg::OPC_LSB])
      bbsd_pkg::OPC_RELATIVE_JUMP: begin
        if (ir_q[bbsd_pkg::JUMP_FIX_POS] == bbsd_pkg::JUMP_FIXED_BIT) begin
          dec_op = bbsd_pkg::OP_JUMP;
        end else begin
          dec_op = bbsd_pkg::OP_NONE;
        end
      end
      bbsd_pkg::OPC_BIT_FORCE_ONE: dec_op = bbsd_pkg::OP_FORCE;
      bbsd_pkg::OPC_TEST_SKIP_ZERO: dec_op = bbsd_pkg::OP_SKIP_ZERO;
      bbsd_pkg::OPC_TEST_SKIP_ONE: dec_op = bbsd_pkg::OP_SKIP_ONE;
      default: dec_op = bbsd_pkg::OP_NONE;
    endcase
  end

  // A discarded word executes as a no-operation
  assign flushing = (flush_cnt_q != 2'h0);
  assign exec_op = flushing ? bbsd_pkg::OP_NONE : dec_op;

  // Offset doubled and sign-extended to the PC width
  assign jump_ofs = {{9{ir_q[bbsd_pkg::JUMP_OFS_MSB]}}, ir_q[bbsd_pkg::JUMP_OFS_MSB:0], 1'b0};

  // ----------------------------------------------------------------
  // Operand address
  // ----------------------------------------------------------------
  bbsd_addr_if af ();

  assign af.file_lit = ir_q[bbsd_pkg::FILE_MSB:0];
  assign af.acc_flag = ir_q[bbsd_pkg::ACC_POS];
  assign af.bank_sel = bank_select_pointer;
  assign af.ext_en = ext_set_en;
  assign af.index_base = index_base;

  bbsd_addr_former u_addr (
    .p(af.former)
  );

  // ----------------------------------------------------------------
  // Bit datapath
  // ----------------------------------------------------------------
  logic is_bit_op;
  logic [11:0] file_addr_q;
  logic [2:0] bit_sel_q;
  logic [7:0] rdata_q;
  logic [7:0] wdata_q;
  logic bit_val_q;
  logic skip_take;

  assign is_bit_op = (exec_op == bbsd_pkg::OP_FORCE) || (exec_op == bbsd_pkg::OP_SKIP_ZERO)
                     || (exec_op == bbsd_pkg::OP_SKIP_ONE);

  // Q1: decode, latch address and bit index
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      file_addr_q <= 12'h000;
      bit_sel_q <= 3'h0;
    end else if (phase_q == bbsd_pkg::PH_Q1) begin
      file_addr_q <= af.addr;
      bit_sel_q <= ir_q[bbsd_pkg::BIT_MSB:bbsd_pkg::BIT_LSB];
    end
  end

  // Q2: read register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (file_rd) begin
      rdata_q <= file_rdata;
    end
  end

  // Q3: process data
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wdata_q <= 8'h00;
      bit_val_q <= 1'b0;
    end else if (phase_q == bbsd_pkg::PH_Q3) begin
      wdata_q <= rdata_q | (8'h01 << bit_sel_q);
      bit_val_q <= rdata_q[bit_sel_q];
    end
  end

  assign file_rd = (phase_q == bbsd_pkg::PH_Q2) && is_bit_op;
  // Q4: write back; only the force instruction writes
  assign file_wr = q4 && (exec_op == bbsd_pkg::OP_FORCE);

  assign skip_take = ((exec_op == bbsd_pkg::OP_SKIP_ZERO) && !bit_val_q)
                     || ((exec_op == bbsd_pkg::OP_SKIP_ONE) && bit_val_q);

  // ----------------------------------------------------------------
  // Pipeline: instruction register, flush count, program counter
  // ----------------------------------------------------------------
  // Reset contents of the instruction register are never executed
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ir_q <= bbsd_pkg::IR_RESET;
    end else if (q4) begin
      ir_q <= fetch_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      flush_cnt_q <= bbsd_pkg::FLUSH_RESET;
    end else if (q4) begin
      if (exec_op == bbsd_pkg::OP_JUMP) begin
        flush_cnt_q <= bbsd_pkg::FLUSH_ONE;
      end else if (skip_take && fetch_two_word) begin
        // Both words of the skipped instruction are discarded
        flush_cnt_q <= bbsd_pkg::FLUSH_TWO;
      end else if (skip_take) begin
        flush_cnt_q <= bbsd_pkg::FLUSH_ONE;
      end else if (flushing) begin
        flush_cnt_q <= flush_cnt_q - 2'h1;
      end
    end
  end

  logic [20:0] pc_q_reg;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pc_q_reg <= bbsd_pkg::PC_RESET;
    end else if (q4) begin
      if (exec_op == bbsd_pkg::OP_JUMP) begin
        // pc already points past the jump, so this gives PC + 2 + 2n
        pc_q_reg <= pc_q_reg + jump_ofs;
      end else begin
        pc_q_reg <= pc_q_reg + bbsd_pkg::PC_STEP;
      end
    end
  end

  // Unknown opcodes belong to other decoders; flagged once per cycle
  logic op_unhandled_q;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      op_unhandled_q <= 1'b0;
    end else begin
      op_unhandled_q <= q4 && !flushing && (dec_op == bbsd_pkg::OP_NONE);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // No instruction here ever writes the arithmetic flags
  logic status_we_q;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      status_we_q <= 1'b0;
    end else begin
      status_we_q <= 1'b0;
    end
  end

  assign pc = pc_q_reg;
  assign fetch_strobe = q4;
  assign file_addr = file_addr_q;
  assign file_wdata = wdata_q;
  assign status_we = status_we_q;
  assign flush_active = flushing;
  assign op_unhandled = op_unhandled_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_JUMP_DECODE: assert property (@(posedge core_clk) disable iff (!resetn)
    (!flushing && ir_q[15:11] == 5'b11010) |-> exec_op == bbsd_pkg::OP_JUMP)
    else $error("relative jump opcode not decoded");

  AST_JUMP_TARGET: assert property (@(posedge core_clk) disable iff (!resetn)
    (q4 && exec_op == bbsd_pkg::OP_JUMP) |=> pc == $past(pc) + $past(jump_ofs))
    else $error("jump target is not pc plus twice the offset");

  AST_JUMP_TWO_CYCLES: assert property (@(posedge core_clk) disable iff (!resetn)
    (q4 && exec_op == bbsd_pkg::OP_JUMP) |=> flushing [*4] ##1 !flushing)
    else $error("jump did not spend exactly one no-operation cycle");

  AST_FORCE_WRITE: assert property (@(posedge core_clk) disable iff (!resetn)
    (phase_q == bbsd_pkg::PH_Q2 && exec_op == bbsd_pkg::OP_FORCE)
    |=> ##1 (file_wr && file_wdata == ($past(file_rdata, 2) | (8'h01 << bit_sel_q))))
    else $error("bit force did not write the read value with the bit set");

  AST_ACCESS_BANK: assert property (@(posedge core_clk) disable iff (!resetn)
    (!af.acc_flag && !(ext_set_en && af.file_lit <= 8'h5f))
    |-> af.addr == ((af.file_lit <= 8'h5f) ? {4'h0, af.file_lit} : {4'hf, af.file_lit}))
    else $error("access bank address wrong");

  AST_BANKED: assert property (@(posedge core_clk) disable iff (!resetn)
    af.acc_flag |-> af.addr == {bank_select_pointer, af.file_lit})
    else $error("banked address does not use the bank pointer");

  AST_INDEXED: assert property (@(posedge core_clk) disable iff (!resetn)
    (!af.acc_flag && ext_set_en && af.file_lit <= 8'h5f)
    |-> (af.mode == bbsd_pkg::AM_INDEXED && af.addr == index_base + {4'h0, af.file_lit}))
    else $error("indexed literal offset address wrong");

  AST_SKIP_ZERO: assert property (@(posedge core_clk) disable iff (!resetn)
    (q4 && exec_op == bbsd_pkg::OP_SKIP_ZERO && !bit_val_q) |=> flushing)
    else $error("skip on zero not taken");

  AST_SKIP_ONE: assert property (@(posedge core_clk) disable iff (!resetn)
    (q4 && exec_op == bbsd_pkg::OP_SKIP_ONE) |=> (flushing == $past(bit_val_q)))
    else $error("skip on one taken wrongly");

  AST_SKIP_NOP: assert property (@(posedge core_clk) disable iff (!resetn)
    flushing |-> (!file_wr && !file_rd && exec_op == bbsd_pkg::OP_NONE))
    else $error("discarded instruction had an effect");

  AST_SKIP_TWO_WORD: assert property (@(posedge core_clk) disable iff (!resetn)
    (q4 && skip_take && fetch_two_word) |=> flushing [*8])
    else $error("skip over two-word instruction not three cycles");

  AST_FORCE_Q4_ONLY: assert property (@(posedge core_clk) disable iff (!resetn)
    file_wr |-> (q4 && $past(phase_q == bbsd_pkg::PH_Q3)))
    else $error("write back outside the final phase");

  AST_FLAGS_KEPT: assert property (@(posedge core_clk) disable iff (!resetn)
    (exec_op != bbsd_pkg::OP_NONE) |=> !status_we)
    else $error("status flags written");

endmodule // bbsd_core

// File: bbsd_pkg.sv
// Shared constants and types for the branch / bit-set / bit-test decode block.
// Assumes one 25 MHz core clock; four core clocks make one instruction cycle.
package bbsd_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W = 21;
  localparam int ADDR_W = 12;
  localparam int INSTR_W = 16;

  // ----------------------------------------------------------------
  // Opcode prefixes (instruction bits 15:12)
  // ----------------------------------------------------------------
  localparam logic [3:0] OPC_RELATIVE_JUMP = 4'hd;
  localparam logic [3:0] OPC_BIT_FORCE_ONE = 4'h8;
  localparam logic [3:0] OPC_TEST_SKIP_ZERO = 4'hb;
  localparam logic [3:0] OPC_TEST_SKIP_ONE = 4'ha;
  localparam logic JUMP_FIXED_BIT = 1'b0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 12;
  localparam int JUMP_FIX_POS = 11;
  localparam int JUMP_OFS_MSB = 10;
  localparam int BIT_MSB = 11;
  localparam int BIT_LSB = 9;
  localparam int ACC_POS = 8;
  localparam int FILE_MSB = 7;

  // ----------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------
  localparam logic [7:0] ACCESS_LOW_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [INSTR_W-1:0] IR_RESET = 16'h0000;
  localparam logic [1:0] FLUSH_RESET = 2'h1;
  localparam logic [1:0] FLUSH_ONE = 2'h1;
  localparam logic [1:0] FLUSH_TWO = 2'h2;
  localparam int CLKS_PER_ICYCLE = 4;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} bbsd_phase_t;
  typedef enum logic [1:0] {AM_ACCESS, AM_BANKED, AM_INDEXED} bbsd_amode_t;
  typedef enum logic [2:0] {OP_NONE, OP_JUMP, OP_FORCE, OP_SKIP_ZERO, OP_SKIP_ONE} bbsd_op_t;

endpackage

// File: branch_bitset_skip_decode_bench.sv
// Self-checking bench for the branch / bit-set / bit-test decode block.
// Assumes bbsd_pkg and the design files are compiled first; the bench plays memory itself.
`timescale 1ns/1ps
module branch_bitset_skip_decode_bench;
  localparam int CLK_NS = 40;
  logic core_clk, resetn;
  logic [15:0] fetch_word;
  logic fetch_two_word, fetch_strobe, file_rd, file_wr, ext_set_en, status_we, flush_active, op_unhandled;
  logic [20:0] pc;
  logic [11:0] file_addr, index_base, wr_addr, rd_addr;
  logic [7:0] file_rdata, file_wdata, wr_data;
  logic [3:0] bank_select_pointer;
  logic [15:0] mem [int];
  logic tw_mem [int];
  logic [20:0] pcs [$];
  int error_cnt, compares, cyc, s0, rd_cnt, wr_cnt, rd_cyc, wr_cyc, flush_cnt, stat_cnt, unh_cyc;

  bbsd_core i_bbsd_core (.core_clk(core_clk), .resetn(resetn), .fetch_word(fetch_word),
    .fetch_two_word(fetch_two_word), .fetch_strobe(fetch_strobe), .pc(pc), .file_addr(file_addr),
    .file_rd(file_rd), .file_rdata(file_rdata), .file_wr(file_wr), .file_wdata(file_wdata),
    .bank_select_pointer(bank_select_pointer), .ext_set_en(ext_set_en), .index_base(index_base),
    .status_we(status_we), .flush_active(flush_active), .op_unhandled(op_unhandled));

  initial begin
    core_clk = 1'b0;
    forever #(CLK_NS / 2) core_clk = ~core_clk;
  end

  // Word at pc presented one cycle after pc moves, well ahead of the next Q4
  always @(posedge core_clk) begin
    fetch_word <= mem.exists(int'(pc)) ? mem[int'(pc)] : 16'h0000;
    fetch_two_word <= tw_mem.exists(int'(pc)) ? tw_mem[int'(pc)] : 1'b0;
  end

  // Sampled mid-cycle so every strobe has settled
  always @(negedge core_clk) begin
    if (resetn === 1'b1) begin
      if (fetch_strobe === 1'b1) begin
        if (s0 < 0) s0 = cyc;
        pcs.push_back(pc);
      end
      if (file_rd === 1'b1) begin
        if (rd_cnt == 0) begin
          rd_cyc = cyc;
          rd_addr = file_addr;
        end
        rd_cnt++;
      end
      if (file_wr === 1'b1) begin
        if (wr_cnt == 0) begin
          wr_cyc = cyc;
          wr_addr = file_addr;
          wr_data = file_wdata;
        end
        wr_cnt++;
      end
      if (flush_active === 1'b1 && s0 >= 0 && cyc > s0 + 4 && cyc <= s0 + 16) flush_cnt++;
      if (status_we !== 1'b0) stat_cnt++;
      if (op_unhandled === 1'b1 && unh_cyc < 0) unh_cyc = cyc;
      cyc++;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Reset, settle the addressing inputs, then let the program run
  task automatic run_prog(input logic [3:0] bank, input logic ext, input logic [11:0] base,
                          input logic [7:0] rdata, input int n_cyc);
    @(posedge core_clk);
    resetn <= 1'b0;
    bank_select_pointer <= bank;
    ext_set_en <= ext;
    index_base <= base;
    file_rdata <= rdata;
    repeat (6) @(posedge core_clk);
    cyc = 0;
    s0 = -1;
    rd_cnt = 0;
    wr_cnt = 0;
    flush_cnt = 0;
    stat_cnt = 0;
    unh_cyc = -1;
    pcs.delete();
    resetn <= 1'b1;
    repeat (n_cyc) @(posedge core_clk);
  endtask

  function automatic logic [11:0] exp_addr(logic [7:0] f, logic a, logic ext, logic [3:0] bank, logic [11:0] base);
    if (a) return {bank, f};
    if (ext && f <= 8'h5f) return base + {4'h0, f};
    return (f <= 8'h5f) ? {4'h0, f} : {4'hf, f};
  endfunction

  function automatic logic [15:0] force_word(logic [7:0] f);
    return {bbsd_pkg::OPC_BIT_FORCE_ONE, 3'h0, 1'b0, f};
  endfunction

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    $display("watchdog expired at %0t", $time);
    complete_run();
  end

  initial begin : main
    logic [7:0] f, rd;
    logic [2:0] b;
    logic a, ext, taken;
    logic [3:0] bank, op;
    logic [11:0] base;
    logic [10:0] n;
    logic [20:0] tgt;
    resetn = 1'b0;
    fetch_word = 16'h0000;
    fetch_two_word = 1'b0;
    file_rdata = 8'h00;
    bank_select_pointer = 4'h0;
    ext_set_en = 1'b0;
    index_base = 12'h000;
    error_cnt = 0;
    compares = 0;
    s0 = -1;
    void'($urandom(6626));
    // ------------------------------------------------------------
    // Bit force across all addressing modes, boundary 5Fh first
    // ------------------------------------------------------------
    for (int i = 0; i < 12; i++) begin
      f = $urandom;
      b = $urandom;
      a = $urandom;
      ext = $urandom;
      bank = $urandom;
      base = $urandom;
      rd = $urandom;
      case (i)
        0: begin f = 8'h5f; a = 1'b0; ext = 1'b1; end
        1: begin f = 8'h60; a = 1'b0; ext = 1'b1; end
        2: begin f = 8'h5f; a = 1'b0; ext = 1'b0; end
        3: begin f = 8'hff; a = 1'b1; end
        default: ;
      endcase
      mem.delete();
      tw_mem.delete();
      mem[0] = {bbsd_pkg::OPC_BIT_FORCE_ONE, b, a, f};
      run_prog(bank, ext, base, rd, 24);
      check(wr_cnt, 1);
      check(rd_addr, exp_addr(f, a, ext, bank, base));
      check(wr_addr, exp_addr(f, a, ext, bank, base));
      check(wr_data, rd | (8'h01 << b));
      check(rd_cyc, s0 + 2);
      check(wr_cyc, s0 + 4);
      check(stat_cnt, 0);
    end
    $display("test bit force done");
    // ------------------------------------------------------------
    // Relative jump: extreme offsets, random ones, bit 11 set
    // ------------------------------------------------------------
    for (int i = 0; i < 7; i++) begin
      // From 3, so a negated offset never lands on or wraps just below the jump
      n = (i == 0) ? 11'h400 : (i == 1) ? 11'h3ff : 11'($urandom_range(3, 1000));
      if (i > 3) n = -n;
      tgt = (i == 6) ? 21'h000004 : 21'h000002 + {{9{n[10]}}, n, 1'b0};
      mem.delete();
      mem[0] = {bbsd_pkg::OPC_RELATIVE_JUMP, (i == 6), n};
      mem[2] = force_word(8'h10);
      mem[int'(tgt)] = force_word(8'h20);
      run_prog(4'h0, 1'b0, 12'h000, 8'h00, 40);
      check(pcs[2], tgt);
      check(wr_addr, (i == 6) ? 12'h010 : 12'h020);
      check(wr_cyc, s0 + ((i == 6) ? 8 : 12));
      check(flush_cnt, (i == 6) ? 0 : 4);
      check(unh_cyc, s0 + ((i == 6) ? 5 : 17));
      check(stat_cnt, 0);
    end
    $display("test relative jump done");
    // ------------------------------------------------------------
    // Both skips, each outcome, over one- and two-word followers
    // ------------------------------------------------------------
    for (int i = 0; i < 16; i++) begin
      op = i[0] ? bbsd_pkg::OPC_TEST_SKIP_ZERO : bbsd_pkg::OPC_TEST_SKIP_ONE;
      f = $urandom;
      b = $urandom;
      bank = $urandom;
      rd = $urandom;
      rd[b] = i[1];
      taken = i[0] ? !rd[b] : rd[b];
      mem.delete();
      tw_mem.delete();
      mem[0] = {op, b, 1'b1, f};
      mem[2] = i[2] ? 16'h0000 : force_word(8'h10);
      tw_mem[2] = i[2];
      mem[4] = i[2] ? 16'h0000 : force_word(8'h20);
      mem[6] = force_word(8'h30);
      run_prog(bank, 1'b0, 12'h000, rd, 40);
      check(rd_addr, {bank, f});
      if (i[2]) begin
        check(wr_addr, 12'h030);
        check(flush_cnt, taken ? 8 : 0);
      end else begin
        check(wr_addr, taken ? 12'h020 : 12'h010);
        check(wr_cyc, s0 + (taken ? 12 : 8));
        check(flush_cnt, taken ? 4 : 0);
      end
      check(stat_cnt, 0);
    end
    $display("test bit skip done");
    complete_run();
  end
endmodule // branch_bitset_skip_decode_bench
